// ### hdl/tca_consts.vh
// Constants shared by the timer compare action unit
`ifndef TCA_CONSTS_VH
`define TCA_CONSTS_VH

// ----------------------------------------------------------------------
// Banked port map
// ----------------------------------------------------------------------
`define TCA_BANK_W        4
`define TCA_ADDR_W        3
`define TCA_BANK_CTRL     4'h2
`define TCA_ADDR_CTRL     3'h4
`define TCA_BANK_MATCH    4'h3
`define TCA_BANK_ACTION   4'h4
`define TCA_LAST_ADDR     3'h5

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define TCA_CTRL_PIN_B    12
`define TCA_CTRL_PIN_A    11
`define TCA_CTRL_ENABLE   10
`define TCA_CTRL_TSEL     9
`define TCA_CTRL_PWM      8

// ----------------------------------------------------------------------
// Action register fields
// ----------------------------------------------------------------------
`define TCA_CHANNELS      6
`define TCA_DEDICATED     4
`define TCA_CH_PIN_A      4
`define TCA_CH_PIN_B      5
`define TCA_ACT_TOP       15
`define TCA_ACT_IRQ_A     3
`define TCA_ACT_IRQ_B     2
`define TCA_PIN_KEEP      2'h0
`define TCA_PIN_LOW       2'h1
`define TCA_PIN_HIGH      2'h2
`define TCA_PIN_TOGGLE    2'h3

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define TCA_DATA_W        16
`define TCA_COARSE_W      14
`define TCA_FINE_W        2
`define TCA_WORD_RESET    16'h0000

`endif

// ### hdl/tca_fine_delay.v
// Fine step delay of 0 to 3 input clock cycles for one PWM channel
`timescale 1ns/10ps

module tca_fine_delay #(
  parameter FINE_W = 2
) (
  input  wire              sys_clk,
  input  wire              rst,
  input  wire              start,
  input  wire [FINE_W-1:0] delay,
  output wire              fire
);

  reg [FINE_W-1:0] cnt_r;
  reg              busy_r;

  // Zero delay fires at once, otherwise after delay cycles
  assign fire = (start & (delay == {FINE_W{1'b0}})) | (busy_r & (cnt_r == {{(FINE_W-1){1'b0}}, 1'b1}));

  always @(posedge sys_clk) begin
    if (rst) begin
      cnt_r  <= {FINE_W{1'b0}};
      busy_r <= 1'b0;
    end else if (start && (delay != {FINE_W{1'b0}})) begin
      cnt_r  <= delay;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      cnt_r  <= cnt_r - {{(FINE_W-1){1'b0}}, 1'b1};
      busy_r <= (cnt_r != {{(FINE_W-1){1'b0}}, 1'b1});
    end
  end

endmodule // tca_fine_delay

// ### hdl/tca_match_slot.v
// One compare channel: equality against the selected timer, once per timer value
`timescale 1ns/10ps

module tca_match_slot #(
  parameter DATA_W   = 16,
  parameter COARSE_W = 14
) (
  input  wire              sys_clk,
  input  wire              rst,
  input  wire [DATA_W-1:0] timerVal,
  input  wire [DATA_W-1:0] matchVal,
  input  wire              pwmMode,
  input  wire              enable,
  input  wire              timerMoved,
  output wire              hit
);

  reg  eqPrev_r;
  wire eqFull;
  wire eqCoarse;
  wire eq;

  assign eqFull   = (timerVal == matchVal);
  assign eqCoarse = (timerVal[COARSE_W-1:0] == matchVal[DATA_W-1:DATA_W-COARSE_W]);
  assign eq       = pwmMode ? eqCoarse : eqFull;
  // Fire on a new timer value or on the first cycle of equality
  assign hit      = enable & eq & (timerMoved | ~eqPrev_r);

  always @(posedge sys_clk) begin
    if (rst) begin
      eqPrev_r <= 1'b0;
    end else begin
      eqPrev_r <= eq;
    end
  end

endmodule // tca_match_slot

// ### hdl/tca_top.v
// Timer compare action unit: match and action registers, pin actions, PWM mode
`timescale 1ns/10ps
`include "tca_consts.vh"

// How it works
// - Six 16-bit match values compared with timer
// - Normal-mode match applies its own action register
// - Control bit 12 makes pin b output
// - Control bit 11 makes pin a output
// - Bit 10 low: pins, values zero, no irq
// - Control bit 9 selects timer two
// - Control bit 8 selects PWM mode
// - PWM match drives its pin low
// - PWM: action register buffers match value
// - Match values at bank 3, ports 0-5
// - Action registers at bank 4, ports 0-5
// - Two-bit pin fields from 15:14 to 5:4
// - Field: keep, low, high, toggle
// - Action bit 3 raises interrupt a
// - Action bit 2 raises interrupt b
// - Reset: outputs low, shared pins inputs
// - PWM: coarse match plus 0-3 fine cycles
// - PWM period: set pins, clear, reload
module tca_top #(
  parameter DATA_W   = `TCA_DATA_W,
  parameter COARSE_W = `TCA_COARSE_W,
  parameter FINE_W   = `TCA_FINE_W
) (
  input  wire                   sys_clk,
  input  wire                   rst,
  input  wire [`TCA_BANK_W-1:0] portBank,
  input  wire [`TCA_ADDR_W-1:0] portAddr,
  input  wire                   portWrite,
  input  wire                   portRead,
  input  wire [DATA_W-1:0]      portWData,
  output reg  [DATA_W-1:0]      portRData_r,
  input  wire [DATA_W-1:0]      timerOne,
  input  wire [DATA_W-1:0]      timerTwo,
  input  wire [DATA_W-1:0]      periodOne,
  input  wire [DATA_W-1:0]      periodTwo,
  output reg  [3:0]             waveOut_r,
  output reg                    sharedPinAOut_r,
  output reg                    sharedPinAOe_r,
  output reg                    sharedPinBOut_r,
  output reg                    sharedPinBOe_r,
  output reg                    matchIrqA_r,
  output reg                    matchIrqB_r,
  output reg                    timerClear_r
);

  // --------------------------------------------------------------------
  // Channel roles
  // --------------------------------------------------------------------
  localparam DEDICATED = `TCA_DEDICATED;
  localparam CH_PIN_A  = `TCA_CH_PIN_A;
  localparam CH_PIN_B  = `TCA_CH_PIN_B;

  // --------------------------------------------------------------------
  // Storage and state
  // --------------------------------------------------------------------
  reg  [DATA_W-1:0]         matchVal_r [0:`TCA_CHANNELS-1];
  reg  [DATA_W-1:0]         actionVal_r [0:`TCA_CHANNELS-1];
  reg                       enable_r;
  reg                       timerSel_r;
  reg                       pwmMode_r;
  reg  [DATA_W-1:0]         timerPrev_r;
  reg                       periodEqPrev_r;
  reg  [`TCA_CHANNELS-1:0]  pinState_r;

  reg  [`TCA_CHANNELS-1:0]  pinNxt;
  reg                       irqANxt;
  reg                       irqBNxt;
  reg  [DATA_W-1:0]         rDataNxt;
  reg  [DATA_W-1:0]         actTmp;
  integer                   c;
  integer                   p;

  wire [DATA_W-1:0]         selTimer;
  wire [DATA_W-1:0]         selPeriod;
  wire                      timerMoved;
  wire                      periodEq;
  wire                      periodHit;
  wire [`TCA_CHANNELS-1:0]  hit;
  wire [`TCA_CHANNELS-1:0]  fire;
  wire [`TCA_CHANNELS-1:0]  fineStart;
  wire                      pwmActive;
  wire                      ctrlWrite;
  wire                      matchWrite;
  wire                      actionWrite;

  // --------------------------------------------------------------------
  // Timer selection and period detection
  // --------------------------------------------------------------------
  assign selTimer   = timerSel_r ? timerTwo : timerOne;
  assign selPeriod  = timerSel_r ? periodTwo : periodOne;
  assign timerMoved = (selTimer != timerPrev_r);
  assign periodEq   = (selTimer[COARSE_W-1:0] == selPeriod[COARSE_W-1:0]);
  assign pwmActive  = enable_r & pwmMode_r;
  assign periodHit  = pwmActive & periodEq & (timerMoved | ~periodEqPrev_r);

  always @(posedge sys_clk) begin
    if (rst) begin
      timerPrev_r    <= `TCA_WORD_RESET;
      periodEqPrev_r <= 1'b0;
    end else begin
      timerPrev_r    <= selTimer;
      periodEqPrev_r <= periodEq;
    end
  end

  // Clear request goes out once, on the edge after the period match
  always @(posedge sys_clk) begin
    if (rst) begin
      timerClear_r <= 1'b0;
    end else begin
      timerClear_r <= periodHit;
    end
  end

  // --------------------------------------------------------------------
  // Port decode
  // --------------------------------------------------------------------
  assign ctrlWrite   = portWrite & (portBank == `TCA_BANK_CTRL) & (portAddr == `TCA_ADDR_CTRL);
  assign matchWrite  = portWrite & (portBank == `TCA_BANK_MATCH);
  assign actionWrite = portWrite & (portBank == `TCA_BANK_ACTION);

  // --------------------------------------------------------------------
  // Control bits
  // --------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      sharedPinBOe_r <= 1'b0;
      sharedPinAOe_r <= 1'b0;
      enable_r       <= 1'b0;
      timerSel_r     <= 1'b0;
      pwmMode_r      <= 1'b0;
    end else if (ctrlWrite) begin
      sharedPinBOe_r <= portWData[`TCA_CTRL_PIN_B];
      sharedPinAOe_r <= portWData[`TCA_CTRL_PIN_A];
      enable_r       <= portWData[`TCA_CTRL_ENABLE];
      timerSel_r     <= portWData[`TCA_CTRL_TSEL];
      pwmMode_r      <= portWData[`TCA_CTRL_PWM];
    end
  end

  // --------------------------------------------------------------------
  // Per channel registers, comparators and fine delays
  // --------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < `TCA_CHANNELS; ch = ch + 1) begin : gChan
      localparam [`TCA_ADDR_W-1:0] IDX = ch;

      always @(posedge sys_clk) begin
        if (rst) begin
          matchVal_r[ch] <= `TCA_WORD_RESET;
        end else if (!enable_r) begin
          matchVal_r[ch] <= `TCA_WORD_RESET;
        end else if (periodHit) begin
          matchVal_r[ch] <= actionVal_r[ch];
        end else if (matchWrite && (portAddr == IDX)) begin
          matchVal_r[ch] <= portWData;
        end
      end

      always @(posedge sys_clk) begin
        if (rst) begin
          actionVal_r[ch] <= `TCA_WORD_RESET;
        end else if (actionWrite && (portAddr == IDX)) begin
          actionVal_r[ch] <= portWData;
        end
      end

      tca_match_slot #(
        .DATA_W   (DATA_W),
        .COARSE_W (COARSE_W)
      ) uSlot (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .timerVal   (selTimer),
        .matchVal   (matchVal_r[ch]),
        .pwmMode    (pwmMode_r),
        .enable     (enable_r),
        .timerMoved (timerMoved),
        .hit        (hit[ch])
      );

      // Delay is latched at the coarse match, a later reload does not move it
      assign fineStart[ch] = hit[ch] & pwmMode_r;

      tca_fine_delay #(
        .FINE_W (FINE_W)
      ) uFine (
        .sys_clk (sys_clk),
        .rst     (rst),
        .start   (fineStart[ch]),
        .delay   (matchVal_r[ch][FINE_W-1:0]),
        .fire    (fire[ch])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // Pin and interrupt actions
  // --------------------------------------------------------------------
  always @* begin
    pinNxt  = pinState_r;
    irqANxt = 1'b0;
    irqBNxt = 1'b0;
    actTmp  = `TCA_WORD_RESET;
    if (!enable_r) begin
      pinNxt = {`TCA_CHANNELS{1'b0}};
    end else if (!pwmMode_r) begin
      for (c = 0; c < `TCA_CHANNELS; c = c + 1) begin
        if (hit[c]) begin
          actTmp = actionVal_r[c];
          for (p = 0; p < `TCA_CHANNELS; p = p + 1) begin
            case (actTmp[`TCA_ACT_TOP-2*p -: 2])
              `TCA_PIN_LOW:    pinNxt[p] = 1'b0;
              `TCA_PIN_HIGH:   pinNxt[p] = 1'b1;
              `TCA_PIN_TOGGLE: pinNxt[p] = ~pinNxt[p];
              default:         pinNxt[p] = pinNxt[p];
            endcase
          end
          irqANxt = irqANxt | actTmp[`TCA_ACT_IRQ_A];
          irqBNxt = irqBNxt | actTmp[`TCA_ACT_IRQ_B];
        end
      end
    end else begin
      for (c = 0; c < `TCA_CHANNELS; c = c + 1) begin
        if (fire[c]) begin
          pinNxt[c] = 1'b0;
        end
      end
      // Interrupts follow the two shared channels only
      irqANxt = hit[CH_PIN_A];
      irqBNxt = hit[CH_PIN_B];
      if (periodHit) begin
        pinNxt = {`TCA_CHANNELS{1'b1}};
      end
    end
  end

  // --------------------------------------------------------------------
  // Pin outputs
  // --------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      pinState_r      <= {`TCA_CHANNELS{1'b0}};
      waveOut_r       <= {DEDICATED{1'b0}};
      sharedPinAOut_r <= 1'b0;
      sharedPinBOut_r <= 1'b0;
    end else begin
      pinState_r      <= pinNxt;
      waveOut_r       <= pinNxt[DEDICATED-1:0];
      sharedPinAOut_r <= pinNxt[CH_PIN_A];
      sharedPinBOut_r <= pinNxt[CH_PIN_B];
    end
  end

  // --------------------------------------------------------------------
  // Interrupt pulses
  // --------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      matchIrqA_r <= 1'b0;
      matchIrqB_r <= 1'b0;
    end else begin
      matchIrqA_r <= irqANxt;
      matchIrqB_r <= irqBNxt;
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  always @* begin
    rDataNxt = `TCA_WORD_RESET;
    case (portBank)
      `TCA_BANK_CTRL: begin
        if (portAddr == `TCA_ADDR_CTRL) begin
          rDataNxt[`TCA_CTRL_PIN_B]  = sharedPinBOe_r;
          rDataNxt[`TCA_CTRL_PIN_A]  = sharedPinAOe_r;
          rDataNxt[`TCA_CTRL_ENABLE] = enable_r;
          rDataNxt[`TCA_CTRL_TSEL]   = timerSel_r;
          rDataNxt[`TCA_CTRL_PWM]    = pwmMode_r;
        end
      end
      `TCA_BANK_MATCH: begin
        if (portAddr <= `TCA_LAST_ADDR) begin
          rDataNxt = matchVal_r[portAddr];
        end
      end
      `TCA_BANK_ACTION: begin
        if (portAddr <= `TCA_LAST_ADDR) begin
          rDataNxt = actionVal_r[portAddr];
        end
      end
      default: begin
        rDataNxt = `TCA_WORD_RESET;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      portRData_r <= `TCA_WORD_RESET;
    end else if (portRead) begin
      portRData_r <= rDataNxt;
    end
  end

endmodule // tca_top

// ### testbench/tca_pin_load.sv
// External load on the compare pins
`timescale 1ns/10ps
module tca_pin_load (
  input  wire       sys_clk,
  input  wire [3:0] waveIn,
  input  wire       outA,
  input  wire       oeA,
  input  wire       outB,
  input  wire       oeB,
  output wire [5:0] pinLevel
);
  reg capDrive_r = 1'b0;
  // Capture source drives released pins, new level each cycle
  always @(posedge sys_clk) capDrive_r <= ~capDrive_r;
  assign pinLevel = {oeB ? outB : capDrive_r, oeA ? outA : ~capDrive_r, waveIn};
endmodule // tca_pin_load

// ### testbench/tca_top_monitor.sv
// Port checker for the timer compare action unit
`timescale 1ns/10ps
`include "tca_consts.vh"
module tca_top_monitor #(
  parameter DATA_W = 16
) (
  input wire              sys_clk,
  input wire              rst,
  input wire [3:0]        portBank,
  input wire [2:0]        portAddr,
  input wire              portWrite,
  input wire              portRead,
  input wire [DATA_W-1:0] portWData,
  input wire [DATA_W-1:0] portRData_r,
  input wire [DATA_W-1:0] timerOne,
  input wire [DATA_W-1:0] timerTwo,
  input wire [DATA_W-1:0] periodOne,
  input wire [DATA_W-1:0] periodTwo,
  input wire [3:0]        waveOut_r,
  input wire              sharedPinAOut_r,
  input wire              sharedPinAOe_r,
  input wire              sharedPinBOut_r,
  input wire              sharedPinBOe_r,
  input wire              matchIrqA_r,
  input wire              matchIrqB_r,
  input wire              timerClear_r
);
  reg  [4:0]        ctrl_r;
  reg  [1:0]        ctrlAge_r;
  wire              ctrlWr   = portWrite && portBank == `TCA_BANK_CTRL && portAddr == `TCA_ADDR_CTRL;
  wire              settled  = ctrlAge_r == 2'h3;
  wire [DATA_W-1:0] selTimer = ctrl_r[1] ? timerTwo : timerOne;
  // Shadow of control bits 12..8 and cycles since last write
  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r <= 5'h00;
      ctrlAge_r <= 2'h0;
    end else begin
      if (ctrlWr) ctrl_r <= portWData[12:8];
      ctrlAge_r <= ctrlWr ? 2'h0 : ctrlAge_r + {1'b0, !settled};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_quiet;
    $stable(selTimer) && !portWrite && !timerClear_r && settled;
  endsequence
  sequence s_ctrlRead;
    portRead && portBank == `TCA_BANK_CTRL && portAddr == `TCA_ADDR_CTRL;
  endsequence
  a_reset_clears: assert property ($fell(rst) |-> waveOut_r == 4'h0 && !sharedPinAOe_r && !sharedPinBOe_r)
    else $error("outputs not cleared by reset");
  a_pin_a_dir: assert property (settled |-> sharedPinAOe_r == ctrl_r[3])
    else $error("pin a direction wrong");
  a_pin_b_dir: assert property (settled |-> sharedPinBOe_r == ctrl_r[4])
    else $error("pin b direction wrong");
  a_disable_quiet: assert property (settled && !ctrl_r[2] |-> {waveOut_r, sharedPinAOut_r, sharedPinBOut_r, matchIrqA_r, matchIrqB_r} == 8'h00)
    else $error("activity while disabled");
  a_clear_in_pwm: assert property (timerClear_r && settled |-> ctrl_r[2] && ctrl_r[0])
    else $error("timer clear outside pwm mode");
  a_period_sets: assert property (timerClear_r |-> (waveOut_r == 4'hF && sharedPinAOut_r && sharedPinBOut_r) ##1 !timerClear_r)
    else $error("period did not set pins");
  a_ctrl_readback: assert property (s_ctrlRead |=> portRData_r == {3'h0, $past(ctrl_r), 8'h00})
    else $error("control readback wrong");
  a_rdata_holds: assert property (!portRead |=> $stable(portRData_r))
    else $error("read data changed without read");
  a_once_per_value: assert property (s_quiet [*3] |-> !matchIrqA_r && !matchIrqB_r)
    else $error("repeated action on held timer");
endmodule // tca_top_monitor

bind tca_top tca_top_monitor #(.DATA_W(DATA_W)) u_mon (.sys_clk(sys_clk), .rst(rst), .portBank(portBank),
  .portAddr(portAddr), .portWrite(portWrite), .portRead(portRead), .portWData(portWData),
  .portRData_r(portRData_r), .timerOne(timerOne), .timerTwo(timerTwo), .periodOne(periodOne),
  .periodTwo(periodTwo), .waveOut_r(waveOut_r), .sharedPinAOut_r(sharedPinAOut_r),
  .sharedPinAOe_r(sharedPinAOe_r), .sharedPinBOut_r(sharedPinBOut_r), .sharedPinBOe_r(sharedPinBOe_r),
  .matchIrqA_r(matchIrqA_r), .matchIrqB_r(matchIrqB_r), .timerClear_r(timerClear_r));

// ### testbench/testbench.sv
// Self-checking bench for the timer compare action unit
`timescale 1ns/10ps
`include "tca_consts.vh"
module testbench;
  reg         sys_clk, rst = 1'b1, portWrite = 1'b0, portRead = 1'b0, tsel = 1'b0, pwmRun = 1'b0;
  reg  [3:0]  portBank = 4'h0;
  reg  [2:0]  portAddr = 3'h0;
  reg  [15:0] portWData = 16'h0000, timerOne = 16'h0000, timerTwo = 16'h0000;
  reg  [15:0] periodOne = 16'h0000, periodTwo = 16'h0000, tmr = 16'h0000, rdv, act, v;
  reg  [1:0]  div = 2'h0;
  reg  [5:0]  expPins, prevPins;
  reg  [13:0] coarse[0:5];
  reg  [1:0]  fine[0:5];
  wire [15:0] rData;
  wire [3:0]  wave;
  wire [5:0]  pinLevel;
  wire        outA, oeA, outB, oeB, irqA, irqB, tClr;
  integer     failCount = 0, totalChecks = 0, cyc = 0, irqCntA = 0, irqCntB = 0, clrCnt = 0;
  integer     n, i, k, j, setCyc[0:5], fallCyc[0:5], pwmIrqA, pwmIrqB;

  tca_top uut (.sys_clk(sys_clk), .rst(rst), .portBank(portBank), .portAddr(portAddr),
    .portWrite(portWrite), .portRead(portRead), .portWData(portWData), .portRData_r(rData),
    .timerOne(timerOne), .timerTwo(timerTwo), .periodOne(periodOne), .periodTwo(periodTwo),
    .waveOut_r(wave), .sharedPinAOut_r(outA), .sharedPinAOe_r(oeA), .sharedPinBOut_r(outB),
    .sharedPinBOe_r(oeB), .matchIrqA_r(irqA), .matchIrqB_r(irqB), .timerClear_r(tClr));
  tca_pin_load load (.sys_clk(sys_clk), .waveIn(wave), .outA(outA), .oeA(oeA), .outB(outB),
    .oeB(oeB), .pinLevel(pinLevel));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // Timer stand-in, one count per four clocks, and pin watcher
  // ----------------------------------------------------------------
  always @(negedge sys_clk) begin
    if (pwmRun) begin
      if (tClr) tmr = 16'h0000;
      else if (div == 2'h3) tmr = tmr + 16'h0001;
      div = div + 2'h1;
      for (j = 0; j < 6; j = j + 1) begin
        if (clrCnt == 1 && tmr[13:0] == coarse[j] && setCyc[j] < 0) setCyc[j] = cyc;
        if (clrCnt == 1 && prevPins[j] && !pinLevel[j]) fallCyc[j] = cyc;
      end
    end
    if (tClr) clrCnt = clrCnt + 1;
    irqCntA = irqCntA + irqA;
    irqCntB = irqCntB + irqB;
    if (clrCnt == 1) begin
      pwmIrqA = pwmIrqA + irqA;
      pwmIrqB = pwmIrqB + irqB;
    end
    prevPins = pinLevel;
    timerOne <= tsel ? ~tmr : tmr;
    timerTwo <= tsel ? tmr : ~tmr;
  end

  task wr(input [3:0] b, input [2:0] a, input [15:0] d);
    begin
      @(negedge sys_clk);
      {portBank, portAddr, portWData, portWrite} = {b, a, d, 1'b1};
      @(negedge sys_clk);
      portWrite = 1'b0;
    end
  endtask
  task rd(input [3:0] b, input [2:0] a);
    begin
      @(negedge sys_clk);
      {portBank, portAddr, portRead} = {b, a, 1'b1};
      @(negedge sys_clk);
      portRead = 1'b0;
      rdv = rData;
    end
  endtask
  task chk(input string name, input [15:0] seen, input [15:0] exp);
    begin
      totalChecks = totalChecks + 1;
      if (seen !== exp) begin
        failCount = failCount + 1;
        $display("BAD %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", totalChecks, failCount);
      if (failCount == 0 && totalChecks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  function [5:0] apply(input [5:0] p, input [15:0] a);
    integer c;
    begin
      apply = p;
      for (c = 0; c < 6; c = c + 1)
        case (a[15 - 2 * c -: 2])
          `TCA_PIN_LOW: apply[c] = 1'b0;
          `TCA_PIN_HIGH: apply[c] = 1'b1;
          `TCA_PIN_TOGGLE: apply[c] = ~p[c];
          default: ;
        endcase
    end
  endfunction

  initial begin
    n = $urandom(32'h318698A2);
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    // Reset values, disabled match writes, unmapped read
    wr(`TCA_BANK_MATCH, 3'h0, 16'h1234);
    rd(`TCA_BANK_CTRL, `TCA_ADDR_CTRL);
    chk("ctrl", rdv, 16'h0000);
    for (i = 0; i < 6; i = i + 1) begin
      rd(`TCA_BANK_MATCH, i[2:0]);
      chk("match", rdv, 16'h0000);
      rd(`TCA_BANK_ACTION, i[2:0]);
      chk("action", rdv, 16'h0000);
    end
    rd(4'h7, 3'h0);
    chk("unmapped", rdv, 16'h0000);
    chk("pins", {10'h000, outB, outA, wave}, 16'h0000);
    chk("irq", 16'(irqCntA + irqCntB), 16'h0000);
    $display("test reset done");
    // ----------------------------------------------------------------
    // Normal compare, one channel at a time so actions never collide
    // ----------------------------------------------------------------
    tmr = 16'h7777;
    wr(`TCA_BANK_CTRL, `TCA_ADDR_CTRL, 16'h0400);
    expPins = 6'h00;
    for (n = 0; n < 14; n = n + 1) begin
      i = $urandom % 6;
      act = n == 0 ? 16'hFFFF : n == 1 ? 16'hAAA3 : n == 2 ? 16'h555B : 16'($urandom) | 16'h0003;
      v = {n[7:0] + 8'h01, 8'($urandom)};
      for (k = 0; k < 6; k = k + 1)
        wr(`TCA_BANK_MATCH, k[2:0], k == i ? v : 16'hFFFF);
      wr(`TCA_BANK_ACTION, i[2:0], act);
      tsel = $urandom % 2;
      wr(`TCA_BANK_CTRL, `TCA_ADDR_CTRL, {3'h0, 2'($urandom), 1'b1, tsel, 9'h000});
      rd(`TCA_BANK_MATCH, i[2:0]);
      chk("match", rdv, v);
      rd(`TCA_BANK_ACTION, i[2:0]);
      chk("action", rdv, act);
      @(posedge sys_clk);
      irqCntA = 0;
      irqCntB = 0;
      tmr = v;
      repeat (8) @(negedge sys_clk);
      expPins = apply(expPins, act);
      chk("pins", {10'h000, outB, outA, wave}, {10'h000, expPins});
      chk("irq a", irqCntA[15:0], {15'h0000, act[3]});
      chk("irq b", irqCntB[15:0], {15'h0000, act[2]});
    end
    $display("test normal compare done");
    // ----------------------------------------------------------------
    // PWM: coarse match plus fine delay, period reload of match words
    // ----------------------------------------------------------------
    tmr = 16'h0000;
    {periodOne, periodTwo} = tsel ? {16'h0035, 16'h0030} : {16'h0030, 16'h0035};
    wr(`TCA_BANK_CTRL, `TCA_ADDR_CTRL, {3'h0, 2'h3, 1'b1, tsel, 1'b1, 8'h00});
    for (k = 0; k < 6; k = k + 1) begin
      coarse[k] = 14'(1 + $urandom % 40);
      fine[k] = 2'($urandom);
      setCyc[k] = -1;
      fallCyc[k] = -1;
      wr(`TCA_BANK_ACTION, k[2:0], {coarse[k], fine[k]});
    end
    clrCnt = 0;
    pwmIrqA = 0;
    pwmIrqB = 0;
    pwmRun = 1'b1;
    for (n = 0; n < 2000 && clrCnt < 2; n = n + 1)
      @(negedge sys_clk);
    pwmRun = 1'b0;
    chk("clears", clrCnt[15:0], 16'h0002);
    chk("pwm irq a", pwmIrqA[15:0], 16'h0001);
    chk("pwm irq b", pwmIrqB[15:0], 16'h0001);
    for (k = 0; k < 6; k = k + 1) begin
      chk("fall", 16'(fallCyc[k] - setCyc[k]), 16'h0001 + fine[k]);
      rd(`TCA_BANK_MATCH, k[2:0]);
      chk("reload", rdv, {coarse[k], fine[k]});
    end
    $display("test pwm done");
    give_verdict;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    failCount = failCount + 1;
    give_verdict;
  end
endmodule // testbench
